// ---- core/gpt_pkg.sv ----
package gpt_pkg;
  // Register byte offsets
  localparam logic [7:0] GPT_LOAD_LO_OFS = 8'hA0;
  localparam logic [7:0] GPT_LOAD_HI_OFS = 8'hA1;
  localparam logic [7:0] GPT_INT_SRC_OFS = 8'hA2;
  localparam logic [7:0] GPT_CTL_OFS = 8'hA3;
  localparam logic [7:0] GPT_CNT_LO_OFS = 8'hA4;
  localparam logic [7:0] GPT_CNT_HI_OFS = 8'hA5;
  // Field positions
  localparam int GPT_EN_BIT = 0;
  localparam int GPT_RST_BIT = 1;
  localparam int GPT_DIS_BIT = 2;
  localparam int GPT_STS_BIT = 7;
  localparam int GPT_UFLOW_BIT = 0;
  // Reset values
  localparam logic [15:0] GPT_LOAD_RST = 16'hFFFF;
  localparam logic [15:0] GPT_CNT_RST = 16'h0000;
  // Timing
  localparam int GPT_CLK_KHZ = 25000;
  localparam int GPT_TICK_US = 1000;
  localparam int GPT_RELOAD_US = 200;
  localparam int GPT_TICK_CYC = (GPT_TICK_US * GPT_CLK_KHZ) / 1000;
  localparam int GPT_RELOAD_CYC = (GPT_RELOAD_US * GPT_CLK_KHZ + 999) / 1000;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gpt_req_s;

  typedef struct packed {
    logic enable;
    logic auto_disable_on_underflow;
    logic reload_busy;
    logic running;
    logic uflow_pending;
    logic underflow_flag;
    logic [15:0] timer_load_value;
    logic [15:0] timer_count_value;
    logic [15:0] tick_cnt;
    logic [15:0] reload_cnt;
    logic [7:0] rdata;
    logic irq;
  } gpt_state_s;
endpackage

// ---- core/gpt_timer.sv ----
`timescale 1ns/100ps
// Overview of operation
// - Status bit 7 shows timer counting
// - Auto-disable stops timer, clears enable on underflow
// - Auto-disable underflow flag waits until timer halted
// - Reload-reset stops timer, reloads from load
// - Reload-reset bit self-clears after propagation time
// - Enable starts/stops without touching the count
// - Read-only count register, resets to zero
// - Count down load value in millisecond steps
// - Write-one-clear underflow flag drives interrupt
module gpt_timer #(
  parameter int TICK_CYC = gpt_pkg::GPT_TICK_CYC,
  parameter int RELOAD_CYC = gpt_pkg::GPT_RELOAD_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire gpt_pkg::gpt_req_s req,
  output logic [7:0] reg_rdata,
  // Interrupt status contribution
  output logic timer_interrupt_indication
);
  import gpt_pkg::*;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
  localparam logic [15:0] RELOAD_LAST = 16'(RELOAD_CYC - 1);

  gpt_state_s s;
  gpt_state_s next_s;
  logic tick;
  logic uflow_set;

  localparam gpt_state_s STATE_RST = '{
    enable: 1'b0,
    auto_disable_on_underflow: 1'b0,
    reload_busy: 1'b0,
    running: 1'b0,
    uflow_pending: 1'b0,
    underflow_flag: 1'b0,
    timer_load_value: GPT_LOAD_RST,
    timer_count_value: GPT_CNT_RST,
    tick_cnt: 16'h0000,
    reload_cnt: 16'h0000,
    rdata: 8'h00,
    irq: 1'b0
  };

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    tick = s.running && (s.tick_cnt == TICK_LAST);
    // Any hardware set of the underflow flag this cycle
    uflow_set = (tick && (s.timer_count_value <= 16'h0001) && !s.auto_disable_on_underflow) ||
                (s.uflow_pending && !s.running);
    // Prescaler runs only while counting, so a stop keeps the partial ms
    if (s.running) begin
      next_s.tick_cnt = tick ? 16'h0000 : s.tick_cnt + 16'h0001;
    end
    if (tick) begin
      if (s.timer_count_value <= 16'h0001) begin
        if (s.auto_disable_on_underflow) begin
          next_s.timer_count_value = 16'h0000;
          next_s.enable = 1'b0;
          next_s.uflow_pending = 1'b1;
        end else begin
          next_s.timer_count_value = s.timer_load_value;
          next_s.underflow_flag = 1'b1;
        end
      end else begin
        next_s.timer_count_value = s.timer_count_value - 16'h0001;
      end
    end
    // Flag raised only once status reads zero
    if (s.uflow_pending && !s.running) begin
      next_s.uflow_pending = 1'b0;
      next_s.underflow_flag = 1'b1;
    end
    // Reload-reset holds the counter at the load value until done
    if (s.reload_busy) begin
      next_s.timer_count_value = s.timer_load_value;
      next_s.tick_cnt = 16'h0000;
      next_s.reload_cnt = s.reload_cnt + 16'h0001;
      if (s.reload_cnt == RELOAD_LAST) begin
        next_s.reload_busy = 1'b0;
      end
    end
    // Register writes
    if (req.wr) begin
      case (req.addr)
        GPT_LOAD_LO_OFS: next_s.timer_load_value[7:0] = req.wdata;
        GPT_LOAD_HI_OFS: next_s.timer_load_value[15:8] = req.wdata;
        GPT_INT_SRC_OFS: begin
          // Set in the same cycle wins over the clear
          if (req.wdata[GPT_UFLOW_BIT] && !uflow_set) begin
            next_s.underflow_flag = 1'b0;
          end
        end
        GPT_CTL_OFS: begin
          next_s.enable = req.wdata[GPT_EN_BIT];
          next_s.auto_disable_on_underflow = req.wdata[GPT_DIS_BIT];
          if (req.wdata[GPT_RST_BIT]) begin
            next_s.reload_busy = 1'b1;
            next_s.reload_cnt = 16'h0000;
          end
        end
        default: ;
      endcase
    end
    // Counting follows enable, halted during reload-reset
    next_s.running = next_s.enable && !next_s.reload_busy;
    next_s.irq = next_s.underflow_flag;
    // Register reads, data valid the cycle after the strobe
    if (req.rd) begin
      case (req.addr)
        GPT_LOAD_LO_OFS: next_s.rdata = s.timer_load_value[7:0];
        GPT_LOAD_HI_OFS: next_s.rdata = s.timer_load_value[15:8];
        GPT_INT_SRC_OFS: next_s.rdata = {7'h00, s.underflow_flag};
        GPT_CTL_OFS: next_s.rdata = {s.running, 4'h0, s.auto_disable_on_underflow,
                                     s.reload_busy, s.enable};
        GPT_CNT_LO_OFS: next_s.rdata = s.timer_count_value[7:0];
        GPT_CNT_HI_OFS: next_s.rdata = s.timer_count_value[15:8];
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= STATE_RST;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign timer_interrupt_indication = s.irq;

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_ctl_write;
    clk_en && req.wr && (req.addr == GPT_CTL_OFS);
  endsequence

  sequence s_auto_uflow;
    clk_en && tick && (s.timer_count_value <= 16'h0001) && s.auto_disable_on_underflow;
  endsequence

  sequence s_free_uflow;
    clk_en && tick && (s.timer_count_value <= 16'h0001) && !s.auto_disable_on_underflow;
  endsequence

  property p_stop_halts;
    s_ctl_write ##0 !req.wdata[GPT_EN_BIT]
      |=> !s.running;
  endproperty
  a_stop_halts: assert property (p_stop_halts) else $error("status still set after stop");

  property p_auto_stop;
    s_auto_uflow ##0 !(req.wr && (req.addr == GPT_CTL_OFS))
      |=> !s.enable && !s.running && (s.timer_count_value == 16'h0000);
  endproperty
  a_auto_stop: assert property (p_auto_stop) else $error("auto-disable underflow left timer running");

  property p_flag_waits_halt;
    s_auto_uflow ##0 !s.underflow_flag ##1 clk_en
      |-> !s.underflow_flag ##1 s.underflow_flag;
  endproperty
  a_flag_waits_halt: assert property (p_flag_waits_halt) else $error("underflow flag not delayed to halt");

  property p_flag_after_halt;
    $rose(s.underflow_flag) && $past(s.auto_disable_on_underflow)
      |-> !$past(s.running);
  endproperty
  a_flag_after_halt: assert property (p_flag_after_halt) else $error("underflow flag rose while counting");

  property p_reload_start;
    s_ctl_write ##0 req.wdata[GPT_RST_BIT]
      |=> s.reload_busy && !s.running;
  endproperty
  a_reload_start: assert property (p_reload_start) else $error("reload-reset did not start");

  property p_reload_hold;
    clk_en && s.reload_busy
      |=> s.timer_count_value == $past(s.timer_load_value);
  endproperty
  a_reload_hold: assert property (p_reload_hold) else $error("counter not held at load value");

  property p_reload_done;
    $fell(s.reload_busy)
      |-> $past(s.reload_cnt) == RELOAD_LAST;
  endproperty
  a_reload_done: assert property (p_reload_done) else $error("reload-reset cleared early");

  property p_reload_bounded;
    s.reload_busy
      |-> s.reload_cnt <= RELOAD_LAST;
  endproperty
  a_reload_bounded: assert property (p_reload_bounded) else $error("reload-reset overran its span");

  property p_enable_keeps_count;
    s_ctl_write ##0 (!req.wdata[GPT_RST_BIT] && !tick && !s.reload_busy)
      |=> s.timer_count_value == $past(s.timer_count_value);
  endproperty
  a_enable_keeps_count: assert property (p_enable_keeps_count) else $error("enable write moved the count");

  property p_free_reload;
    s_free_uflow
      |=> s.underflow_flag && (s.timer_count_value == $past(s.timer_load_value));
  endproperty
  a_free_reload: assert property (p_free_reload) else $error("free-run underflow did not reload");

  property p_flag_persists;
    clk_en && s.underflow_flag && !(req.wr && (req.addr == GPT_INT_SRC_OFS) && req.wdata[GPT_UFLOW_BIT])
      |=> s.underflow_flag && timer_interrupt_indication;
  endproperty
  a_flag_persists: assert property (p_flag_persists) else $error("underflow flag dropped without clear");

  property p_set_wins;
    clk_en && uflow_set
      |=> s.underflow_flag && timer_interrupt_indication;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("underflow set lost to clear");
endmodule // gpt_timer

// ---- verif/general_purpose_down_timer_bench.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module general_purpose_down_timer_bench;
  import gpt_pkg::*;
  logic sys_clk = 0, rst = 1, clk_en = 1, irq;
  gpt_req_s req = '0;
  logic [7:0] rdata, d, e;
  int fail_count = 0, cmp_count = 0;
  gpt_timer #(.TICK_CYC(4), .RELOAD_CYC(6)) dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .req(req),
    .reg_rdata(rdata), .timer_interrupt_indication(irq));
  always #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req = '{a, v, 1'b1, 1'b0};
    @(posedge sys_clk);
    #1 req = '0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    req = '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    #1 v = rdata;
    req = '0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge sys_clk);
    #1;
    `CHK(irq, 1'b1)
  endtask
  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rst = 0;
    rd(GPT_CTL_OFS, d); `CHK(d, 8'h00)
    rd(GPT_CNT_LO_OFS, d); `CHK(d, 8'h00)
    rd(GPT_CNT_HI_OFS, d); `CHK(d, 8'h00)
    $display("reset values done");
    wr(GPT_LOAD_LO_OFS, 8'h03);
    wr(GPT_LOAD_HI_OFS, 8'h00);
    wr(GPT_CTL_OFS, 8'h02);
    rd(GPT_CTL_OFS, d); `CHK(d[1], 1'b1)
    for (int i = 0; i < 40 && d[1] !== 1'b0; i++) rd(GPT_CTL_OFS, d);
    `CHK(d[1], 1'b0)
    rd(GPT_CNT_LO_OFS, d); `CHK(d, 8'h03)
    $display("reload done");
    wr(GPT_CTL_OFS, 8'h01);
    rd(GPT_CTL_OFS, d); `CHK(d[7], 1'b1)
    repeat (5) @(posedge sys_clk);
    #1 wr(GPT_CTL_OFS, 8'h00);
    rd(GPT_CNT_LO_OFS, d);
    repeat (12) @(posedge sys_clk);
    #1 rd(GPT_CNT_LO_OFS, e); `CHK(e, d)
    `CHK(d < 8'h03 && d > 8'h00, 1'b1)
    $display("start stop done");
    wr(GPT_CTL_OFS, 8'h05);
    wait_irq();
    rd(GPT_CTL_OFS, d); `CHK(d, 8'h04)
    wr(GPT_INT_SRC_OFS, 8'h01);
    `CHK(irq, 1'b0)
    $display("auto disable done");
    wr(GPT_CTL_OFS, 8'h01);
    wait_irq();
    rd(GPT_CTL_OFS, d); `CHK(d, 8'h81)
    clk_en = 0;
    wr(GPT_CTL_OFS, 8'h00);
    clk_en = 1;
    rd(GPT_CTL_OFS, d); `CHK(d, 8'h81)
    wr(GPT_CTL_OFS, 8'h00);
    $display("free run done");
    wrap_up();
  end
  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
endmodule // general_purpose_down_timer_bench
